// >>> logic/datum_search_pkg.sv
// datum search sequencer: shared constants, register map and state type
// assumes one 100 MHz controller clock and a plain strobe register port
package datum_search_pkg;

	// ********************************
	// widths
	// ********************************
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int POS_W = 32;
	localparam int SPD_W = 16;
	localparam int MODE_W = 8;
	localparam int MODE_DEFINED = 5;
	localparam int SYNC_W = 5;
	// edges after reset before synchronised pins and the datum edge detector show real levels
	localparam int SETTLE_CYC = 5;

	// ********************************
	// register offsets (word index)
	// ********************************
	localparam logic [ADDR_W-1:0] OFS_MODE = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_SLEW = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_CREEP = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_HOME = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_CMD = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_DATUM = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h7;

	// ********************************
	// field positions
	// ********************************
	localparam int M_INV_INDEX = 0;
	localparam int M_REPEAT = 1;
	localparam int M_PRESET = 2;
	localparam int M_AUTO_DIR = 3;
	localparam int M_OPP_LIMIT = 4;
	localparam int C_HOME = 0;
	localparam int C_HOME_REV = 1;
	localparam int C_CLEAR = 2;
	localparam int CT_OPEN_LOOP = 0;
	localparam int ST_VALID = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_DIR_NEG = 2;
	localparam int ST_DATUM = 6;

	// synchroniser lanes
	localparam int P_INDEX = 0;
	localparam int P_STOP = 1;
	localparam int P_APPROACH = 2;
	localparam int P_LIM_LOW = 3;
	localparam int P_LIM_HIGH = 4;

	// ********************************
	// reset values
	// ********************************
	localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
	localparam logic [MODE_W-1:0] MODE_MASK = 8'h1F;
	localparam logic [SPD_W-1:0] SLEW_RST = 16'h1000;
	localparam logic [SPD_W-1:0] CREEP_RST = 16'h0100;
	localparam logic [POS_W-1:0] HOME_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_LIMIT = 3'b001,
		S_SEARCH = 3'b011,
		S_REVERSE = 3'b010,
		S_RETURN = 3'b110
	} state_t;

endpackage

// >>> logic/datum_search_sequencer.sv
// datum search sequencer: datum combine, capture and home-to-datum moves
// assumes an external profile generator that follows the run, speed and
// direction outputs and pulses moveDone when a stop or return has settled
`timescale 1ns/1ns
// Notes on behaviour
// (R01) latch actual, or command when open loop
// (R02) fast approach: slew, overshoot, return to datum
// (R03) slow approach: creep, stop at datum
// (R04) approach released: drop to creep at once
// (R05) stop switch opening gives the datum
// (R06) datum is switch open and index high
// (R07) capture also during ordinary moves
// (R08) clear command drops datum; valid flag shown
// (R09) auto search: datum 0 positive, 1 negative
// (R10) capture on rising datum, capture direction only
// (R11) wrong-way search falling edge: stop, reverse
// (R12) capture-direction search latches at once
// (R13) reverse home searches other way, rising capture
// (R14) limit move at slew, then normal search
// (R15) home to lower limit, reverse to upper
// (R16) mode field 8 bits, top three zero
// (R17) mode bit inverts index polarity only
// (R18) mode bit selects once or repeated capture
// (R19) mode bit loads home value on homing
// (R20) mode bits enable auto and limit search
// (R21) both set: limit move, then auto search
// (R22) datum low when stop closed or index low
// (R23) status bit 6 shows datum level
// (R24) inputs synchronised, valid cleared by reset
module datum_search_sequencer
	import datum_search_pkg::*;
#(
	parameter int POS_WIDTH = datum_search_pkg::POS_W,
	parameter int SPD_WIDTH = datum_search_pkg::SPD_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// register port
	input wire logic [datum_search_pkg::ADDR_W-1:0] addr,
	input wire logic [datum_search_pkg::DATA_W-1:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [datum_search_pkg::DATA_W-1:0] rdData,
	// mechanism pins
	input wire logic indexIn,
	input wire logic datumStopInput,
	input wire logic approachSpeedInput,
	input wire logic limitLowIn,
	input wire logic limitHighIn,
	// position sources
	input wire logic [POS_WIDTH-1:0] actualPos,
	input wire logic [POS_WIDTH-1:0] commandPos,
	input wire logic moveDone,
	// motion requests
	output logic moveRun,
	output logic moveDirNeg,
	output logic [SPD_WIDTH-1:0] moveSpeed,
	output logic returnRun,
	output logic [POS_WIDTH-1:0] returnTarget,
	output logic presetLoad,
	output logic [POS_WIDTH-1:0] presetValue,
	output logic datumValid,
	output logic datumLevel
);
	import datum_search_pkg::*;

	initial begin
		if (POS_WIDTH != POS_W) $error("POS_WIDTH must equal POS_W");
		if (SPD_WIDTH != SPD_W) $error("SPD_WIDTH must equal SPD_W");
	end

	// ********************************
	// registers and signals
	// ********************************
	logic [MODE_W-1:0] mode_reg;
	logic [SPD_W-1:0] slew_reg;
	logic [SPD_W-1:0] creep_reg;
	logic [POS_W-1:0] home_reg;
	logic openLoop_reg;
	logic [POS_W-1:0] datum_reg;
	logic valid_reg;
	logic datumPrev_reg;
	logic capNeg_reg;
	logic dirNeg_reg;
	state_t state_reg;
	logic [SYNC_W-1:0] pins;
	logic datumNow, rise, fall, capture, searchCap, idleCap;
	logic cmdWr, startHome, startRev, clearCmd, fast, limitHit;
	logic autoDirNeg;
	logic [SETTLE_CYC-1:0] settle_reg;
	logic settled;

	// ********************************
	// input synchroniser
	// ********************************
	sync_stage3 #(.W(SYNC_W)) u_sync (
		.clk(clk),
		.rstn(rstn),
		.d({limitHighIn, limitLowIn, approachSpeedInput, datumStopInput,
			indexIn}),
		.q(pins)
	); // R24

	// ********************************
	// datum signal
	// ********************************
	// stop switch closed masks the index; polarity bit acts on index only
	assign datumNow = ~pins[P_STOP] &
		(pins[P_INDEX] ^ mode_reg[M_INV_INDEX]); // R06 R17 R22 R05
	assign rise = datumNow & ~datumPrev_reg; // R10 R22
	assign fall = ~datumNow & datumPrev_reg;
	assign fast = pins[P_APPROACH];
	assign autoDirNeg = mode_reg[M_AUTO_DIR] ? (datumNow ^ capNeg_reg)
		: capNeg_reg; // R09 R13

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) datumPrev_reg <= 1'b0;
		else datumPrev_reg <= datumNow;
	end

	// hold off capture until the synchroniser and edge detector have
	// seen real pin levels, so a datum already high at reset is no edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) settle_reg <= '0;
		else settle_reg <= {settle_reg[SETTLE_CYC-2:0], 1'b1}; // R24
	end
	assign settled = settle_reg[SETTLE_CYC-1];

	// ********************************
	// register port decode
	// ********************************
	assign cmdWr = wrStb && addr == OFS_CMD;
	assign startRev = cmdWr && wrData[C_HOME_REV];
	assign startHome = cmdWr && (wrData[C_HOME] || wrData[C_HOME_REV]);
	assign clearCmd = cmdWr && wrData[C_CLEAR];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_reg <= MODE_RST;
			slew_reg <= SLEW_RST;
			creep_reg <= CREEP_RST;
			home_reg <= HOME_RST;
			openLoop_reg <= 1'b0;
		end else if (wrStb) begin
			case (addr)
				OFS_MODE: mode_reg <= wrData[MODE_W-1:0] & MODE_MASK; // R16
				OFS_SLEW: slew_reg <= wrData[SPD_W-1:0];
				OFS_CREEP: creep_reg <= wrData[SPD_W-1:0];
				OFS_HOME: home_reg <= wrData[POS_W-1:0]; // R19
				OFS_CTRL: openLoop_reg <= wrData[CT_OPEN_LOOP];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdData <= '0;
		end else if (rdStb) begin
			case (addr)
				OFS_MODE: rdData <= {24'h000000, mode_reg};
				OFS_SLEW: rdData <= {16'h0000, slew_reg};
				OFS_CREEP: rdData <= {16'h0000, creep_reg};
				OFS_HOME: rdData <= home_reg;
				OFS_STATUS: rdData <= {25'h0000000, datumNow, 3'h0,
					dirNeg_reg, state_reg != S_IDLE, valid_reg}; // R23
				OFS_DATUM: rdData <= datum_reg;
				OFS_CTRL: rdData <= {31'h00000000, openLoop_reg};
				default: rdData <= '0;
			endcase
		end else begin
			rdData <= '0;
		end
	end

	// ********************************
	// capture
	// ********************************
	// homing captures only while travelling in the capture direction
	assign searchCap = state_reg == S_SEARCH
		&& dirNeg_reg == capNeg_reg; // R10 R12
	// outside homing: every pass in repeat mode, else only the first
	assign idleCap = state_reg == S_IDLE
		&& (mode_reg[M_REPEAT] || !valid_reg); // R07 R18
	assign capture = rise && settled
		&& (searchCap || idleCap); // R10 R24

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			datum_reg <= HOME_RST;
		end else if (capture) begin
			if (searchCap && mode_reg[M_PRESET]) datum_reg <= home_reg; // R19
			else if (openLoop_reg) datum_reg <= commandPos; // R01
			else datum_reg <= actualPos; // R01
		end
	end

	// a capture in the same cycle as a clear wins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) valid_reg <= 1'b0; // R24
		else if (capture) valid_reg <= 1'b1; // R08
		else if (clearCmd) valid_reg <= 1'b0; // R08
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			presetLoad <= 1'b0;
			presetValue <= HOME_RST;
		end else begin
			presetLoad <= capture && searchCap && mode_reg[M_PRESET]; // R19
			presetValue <= home_reg;
		end
	end

	// ********************************
	// homing sequence
	// ********************************
	assign limitHit = dirNeg_reg ? pins[P_LIM_LOW] : pins[P_LIM_HIGH];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= S_IDLE;
			dirNeg_reg <= 1'b0;
			capNeg_reg <= 1'b0;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (startHome) begin
						capNeg_reg <= startRev; // R13
						if (mode_reg[M_OPP_LIMIT]) begin
							state_reg <= S_LIMIT; // R20 R21
							dirNeg_reg <= ~startRev; // R15
						end else begin
							state_reg <= S_SEARCH;
							dirNeg_reg <= mode_reg[M_AUTO_DIR] ?
								(datumNow ^ startRev) : startRev; // R09 R20
						end
					end
				end
				S_LIMIT: begin
					if (limitHit) begin
						state_reg <= S_SEARCH; // R14
						dirNeg_reg <= autoDirNeg; // R21 R15
					end
				end
				S_SEARCH: begin
					if (capture) begin
						state_reg <= fast ? S_RETURN : S_IDLE; // R02 R03
					end else if (dirNeg_reg != capNeg_reg && fall) begin
						state_reg <= S_REVERSE; // R11
					end else if (limitHit) begin
						state_reg <= S_IDLE;
					end
				end
				S_REVERSE: begin
					if (moveDone) begin
						state_reg <= S_SEARCH; // R11
						dirNeg_reg <= capNeg_reg;
					end
				end
				S_RETURN: begin
					if (moveDone) state_reg <= S_IDLE; // R02
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// ********************************
	// motion outputs
	// ********************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			moveRun <= 1'b0;
			moveDirNeg <= 1'b0;
			moveSpeed <= '0;
			returnRun <= 1'b0;
			returnTarget <= HOME_RST;
			datumValid <= 1'b0;
			datumLevel <= 1'b0;
		end else begin
			moveRun <= state_reg == S_LIMIT || state_reg == S_SEARCH;
			moveDirNeg <= dirNeg_reg;
			if (state_reg == S_LIMIT) moveSpeed <= slew_reg; // R14
			else if (fast) moveSpeed <= slew_reg; // R02
			else moveSpeed <= creep_reg; // R03 R04
			returnRun <= state_reg == S_RETURN; // R02
			returnTarget <= datum_reg;
			datumValid <= valid_reg; // R08
			datumLevel <= datumNow; // R23
		end
	end

	// ********************************
	// assertions
	// ********************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_mode_reserved_zero: assert property (mode_reg[7:5] == 3'h0) // R16
		else $error("reserved mode bits not zero");
	a_capture_on_rise: assert property (capture |-> datumNow
		&& !datumPrev_reg && !(pins[P_STOP])) // R10
		else $error("capture without rising datum");
	a_clear_drops_valid: assert property (clearCmd && !capture
		|=> !valid_reg ##1 !datumValid) // R08
		else $error("clear did not drop datum");
	a_capture_sets_valid: assert property (capture |=> valid_reg
		##1 datumValid) // R08
		else $error("capture did not set valid");
	a_open_loop_source: assert property (capture && openLoop_reg
		&& !(searchCap && mode_reg[M_PRESET])
		|=> datum_reg == $past(commandPos)) // R01
		else $error("open loop latched wrong position");
	a_closed_loop_source: assert property (capture && !openLoop_reg
		&& !(searchCap && mode_reg[M_PRESET])
		|=> datum_reg == $past(actualPos)) // R01
		else $error("closed loop latched wrong position");
	a_preset_home: assert property (capture && searchCap
		&& mode_reg[M_PRESET] |=> presetLoad
		&& presetValue == $past(home_reg) && datum_reg == $past(home_reg))
		// R19
		else $error("home preset not applied");
	a_creep_speed: assert property (state_reg == S_SEARCH && !fast
		|=> moveSpeed == $past(creep_reg)) // R04
		else $error("not at creep speed");
	a_limit_slew: assert property (state_reg == S_LIMIT
		|=> moveSpeed == $past(slew_reg) && moveRun) // R14
		else $error("limit move not at slew");
	a_auto_direction: assert property (state_reg == S_IDLE && startHome
		&& mode_reg[M_AUTO_DIR] && !mode_reg[M_OPP_LIMIT]
		|=> dirNeg_reg == $past(datumNow ^ startRev)) // R09
		else $error("auto direction wrong");
	a_wrong_way_reverse: assert property (state_reg == S_SEARCH
		&& dirNeg_reg != capNeg_reg && fall |=> state_reg == S_REVERSE
		##1 !moveRun) // R11
		else $error("no reversal on falling datum");
	a_fast_return: assert property (state_reg == S_SEARCH && capture
		&& fast |=> state_reg == S_RETURN ##1 returnRun
		&& returnTarget == datum_reg) // R02
		else $error("fast capture did not return");
	a_status_level: assert property (rdStb && addr == OFS_STATUS
		|=> rdData[ST_DATUM] == $past(datumNow)) // R23
		else $error("status bit 6 wrong");

	c_search_capture: cover property (state_reg == S_SEARCH && capture);
	c_reverse: cover property (state_reg == S_REVERSE ##1 moveDone);
	c_return: cover property (state_reg == S_RETURN ##1 state_reg == S_IDLE);
	c_limit_search: cover property (state_reg == S_LIMIT
		##1 state_reg == S_SEARCH);
endmodule

// >>> logic/sync_stage3.sv
// three-stage input synchroniser, one lane per bit
// assumes asynchronous inputs; a change passes once stages two and three agree
`timescale 1ns/1ns
module sync_stage3 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// lanes
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	initial begin
		if (W < 1) $error("sync_stage3: W must be at least 1");
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// per lane: take the new level only when the last two stages agree
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_reg[i] == s3_reg[i]) q[i] <= s3_reg[i];
			end
		end
	end
endmodule

// >>> tb/datum_search_sequencer_tb.sv
// self-checking bench for the datum search sequencer
// assumes the mechanism model closes the loop on the motion outputs
`timescale 1ns/1ns
module datum_search_sequencer_tb;
	import datum_search_pkg::*;
	localparam int IDX = 100;
	localparam int OFS = 32'h1000;
	typedef struct {
		logic [ADDR_W-1:0] a;
		bit w;
		logic [31:0] d;
		logic [31:0] e;
	} row_t;
	row_t rows[14] = '{
		'{OFS_MODE, 0, 0, MODE_RST}, '{OFS_SLEW, 0, 0, SLEW_RST},
		'{OFS_CREEP, 0, 0, CREEP_RST}, '{OFS_HOME, 0, 0, HOME_RST},
		'{OFS_DATUM, 0, 0, 0}, '{OFS_CTRL, 0, 0, 0},
		'{OFS_STATUS, 0, 0, 0}, '{OFS_MODE, 1, 32'hFF, 32'h1F},
		'{OFS_MODE, 1, 0, 0}, '{OFS_SLEW, 1, 32'h40, 32'h40},
		'{OFS_CREEP, 1, 32'h10, 32'h10}, '{OFS_HOME, 1, 32'h55, 32'h55},
		'{OFS_CMD, 1, 0, 0}, '{4'hC, 1, 32'hFFFF, 0}};
	logic clk, rstn, wrStb, rdStb, approach, stopClosed, jump;
	logic [ADDR_W-1:0] addr;
	logic [31:0] wrData, rdData, jumpPos, actualPos, commandPos;
	logic indexIn, stopIn, limLow, limHigh, moveDone;
	logic moveRun, moveDirNeg, returnRun, presetLoad;
	logic datumValid, datumLevel;
	logic [15:0] moveSpeed;
	logic [31:0] returnTarget, presetValue, d;
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	// ********************************
	// design and mechanism
	// ********************************
	datum_search_sequencer dut (.clk(clk), .rstn(rstn), .addr(addr),
		.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
		.indexIn(indexIn), .datumStopInput(stopIn),
		.approachSpeedInput(approach), .limitLowIn(limLow),
		.limitHighIn(limHigh), .actualPos(actualPos),
		.commandPos(commandPos), .moveDone(moveDone), .moveRun(moveRun),
		.moveDirNeg(moveDirNeg), .moveSpeed(moveSpeed),
		.returnRun(returnRun), .returnTarget(returnTarget),
		.presetLoad(presetLoad), .presetValue(presetValue),
		.datumValid(datumValid), .datumLevel(datumLevel));
	mech_model #(.IDX(IDX), .OFS(OFS)) mech (.clk(clk), .moveRun(moveRun),
		.moveDirNeg(moveDirNeg), .returnRun(returnRun),
		.returnTarget(returnTarget), .stopClosed(stopClosed), .jump(jump),
		.jumpPos(jumpPos), .indexIn(indexIn), .datumStopInput(stopIn),
		.limitLowIn(limLow), .limitHighIn(limHigh), .moveDone(moveDone),
		.actualPos(actualPos), .commandPos(commandPos));
	// ********************************
	// tasks
	// ********************************
	task end_sim;
		if (n_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		@(posedge clk);
		wrStb <= 1;
		addr <= a;
		wrData <= v;
		@(posedge clk);
		wrStb <= 0;
	endtask
	task rd(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		rdStb <= 1;
		addr <= a;
		@(posedge clk);
		rdStb <= 0;
		#1 d = rdData;
	endtask
	task automatic waitfor(ref logic s, input logic v, input int n);
		int i;
		i = 0;
		while (s !== v && i < n) begin
			@(posedge clk);
			#1 i++;
		end
		chk(s === v, "wait ran out");
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task jmp(input logic [31:0] p);
		@(posedge clk);
		jump <= 1;
		jumpPos <= p;
		@(posedge clk);
		jump <= 0;
		tick(8);
	endtask
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			$display("BAD %0t timeout", $time);
			end_sim;
		end
	end
	// ********************************
	// main sequence
	// ********************************
	initial begin
		rstn = 0;
		addr = 0;
		wrData = 0;
		wrStb = 0;
		rdStb = 0;
		approach = 0;
		stopClosed = 0;
		jump = 0;
		jumpPos = 0;
		repeat (2) @(posedge clk);
		rstn <= 1;
		foreach (rows[i]) begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			chk(d === rows[i].e, "register row");
		end
		// slow home from the zero side
		wr(OFS_CMD, 32'h4);
		wr(OFS_CMD, 32'h1);
		tick(3);
		chk(moveRun && !moveDirNeg && moveSpeed === 16'h10, "creep");
		waitfor(datumValid, 1, 500);
		chk(!returnRun && !moveRun, "slow stop");
		rd(OFS_DATUM);
		chk(d >= IDX && d <= IDX + 6, "datum pos");
		rd(OFS_STATUS);
		chk(d[ST_VALID] === 1'b1 && d[ST_DATUM] === 1'b1, "status");
		wr(OFS_CMD, 32'h4);
		tick(3);
		chk(datumValid === 1'b0, "clear");
		// fast auto search started on the one side
		approach <= 1;
		wr(OFS_MODE, 32'h8);
		wr(OFS_CMD, 32'h1);
		tick(3);
		chk(moveDirNeg && moveSpeed === 16'h40, "auto neg");
		waitfor(datumValid, 1, 600);
		waitfor(returnRun, 1, 5);
		waitfor(returnRun, 0, 500);
		rd(OFS_DATUM);
		chk(d >= IDX && d <= IDX + 6, "rev datum");
		chk(actualPos === returnTarget && d === returnTarget, "back");
		// opposite limit, then auto direction
		approach <= 0;
		wr(OFS_MODE, 32'h18);
		wr(OFS_CMD, 32'h4);
		wr(OFS_CMD, 32'h1);
		tick(3);
		chk(moveDirNeg && moveSpeed === 16'h40, "limit move");
		waitfor(moveDirNeg, 0, 400);
		approach <= 1;
		tick(6);
		chk(moveSpeed === 16'h40, "fast");
		approach <= 0;
		tick(6);
		chk(moveSpeed === 16'h10, "drop to creep");
		waitfor(datumValid, 1, 400);
		// reverse home with inverted index
		wr(OFS_MODE, 32'h1);
		tick(6);
		chk(datumLevel === 1'b0, "invert");
		wr(OFS_CMD, 32'h4);
		wr(OFS_CMD, 32'h2);
		tick(3);
		chk(moveRun && moveDirNeg, "reverse dir");
		waitfor(datumValid, 1, 400);
		rd(OFS_DATUM);
		chk(d >= IDX - 7 && d < IDX, "reverse datum");
		// stop switch masking and idle capture
		wr(OFS_MODE, 32'h0);
		wr(OFS_CMD, 32'h4);
		stopClosed <= 1;
		jmp(150);
		chk(datumLevel === 1'b0 && !datumValid, "masked");
		stopClosed <= 0;
		tick(8);
		chk(datumValid === 1'b1, "switch open");
		rd(OFS_DATUM);
		chk(d === 32'd150, "idle datum");
		wr(OFS_CTRL, 32'h1);
		wr(OFS_CMD, 32'h4);
		jmp(50);
		jmp(160);
		rd(OFS_DATUM);
		chk(d === 160 + OFS, "open loop");
		jmp(50);
		jmp(170);
		rd(OFS_DATUM);
		chk(d === 160 + OFS, "once");
		wr(OFS_MODE, 32'h2);
		jmp(50);
		jmp(180);
		rd(OFS_DATUM);
		chk(d === 180 + OFS, "repeat");
		// preset to home value on a homing capture
		wr(OFS_CTRL, 32'h0);
		wr(OFS_MODE, 32'h4);
		jmp(0);
		wr(OFS_CMD, 32'h4);
		wr(OFS_CMD, 32'h1);
		waitfor(presetLoad, 1, 400);
		chk(presetValue === 32'h55, "preset value");
		waitfor(datumValid, 1, 5);
		rd(OFS_DATUM);
		chk(d === 32'h55, "home datum");
		// reset while idle with a datum held
		@(posedge clk);
		rstn <= 0;
		repeat (2) @(posedge clk);
		rstn <= 1;
		tick(1);
		chk(datumValid === 1'b0, "reset");
		tick(8);
		chk(datumValid === 1'b0, "reset edge");
		end_sim;
	end
endmodule

// >>> tb/mech_model.sv
// mechanism model: one axis, index sensor, stop switch and hard limits
// assumes one step per clock while the sequencer asks for motion
`timescale 1ns/1ns
module mech_model #(
	parameter int IDX = 100,
	parameter int HI = 300,
	parameter int OFS = 32'h1000
) (
	// clock
	input wire logic clk,
	// sequencer requests
	input wire logic moveRun,
	input wire logic moveDirNeg,
	input wire logic returnRun,
	input wire logic [31:0] returnTarget,
	// bench controls
	input wire logic stopClosed,
	input wire logic jump,
	input wire logic [31:0] jumpPos,
	// sensors and positions
	output logic indexIn,
	output logic datumStopInput,
	output logic limitLowIn,
	output logic limitHighIn,
	output logic moveDone,
	output logic [31:0] actualPos,
	output logic [31:0] commandPos
);
	logic signed [31:0] pos = 0;
	logic blocked;
	// ********************************
	// travel, halted by the hard stop
	// ********************************
	assign blocked = moveDirNeg ? limitLowIn : limitHighIn;
	always @(posedge clk) begin
		if (jump)
			pos <= jumpPos;
		else if (moveRun && !blocked)
			pos <= moveDirNeg ? pos - 1 : pos + 1;
		else if (returnRun && pos != returnTarget)
			pos <= pos > signed'(returnTarget) ? pos - 1 : pos + 1;
	end
	assign indexIn = pos >= IDX;
	assign datumStopInput = stopClosed;
	assign limitLowIn = pos <= 0;
	assign limitHighIn = pos >= HI;
	assign moveDone = !moveRun && (!returnRun || pos == returnTarget);
	assign actualPos = pos;
	assign commandPos = pos + OFS;
endmodule
